/* verilog/ccb_ctrl.sv */
// Sequencer for data and instruction cache block control operations.
// Assumes lookup results and translation faults arrive with the request.
`timescale 1ns/1ns
// Overview of operation
// - Touch-for-store to a write-through address does nothing.
// - Touch-for-store hitting L1 leaves the block state alone.
// - Touch-for-store L1 miss, L2 hit copies block with L2 state.
// - Touch-for-store total miss fetches RWITM or read-claim, filled block exclusive.
// - Stores to a block with a pending touch fill stall until reload.
// - Block-zero is translated and protection-checked like a store.
// - Block-zero builds zeros; non-coherent pages write them at once.
// - Coherent block-zero hitting modified or exclusive writes at once, no bus.
// - Coherent block-zero hitting shared, recent or missing runs kill first.
// - Zeroed block becomes modified; L2 state untouched.
// - Block-zero disabled, locked, inhibited or write-through: alignment; protection: storage fault.
// - Block-store modified hit writes back, becomes exclusive; other hit or coherent miss clean broadcast; non-coherent miss nothing.
// - Coherent block-store broadcasts; disabled caches stay untouched.
// - Block-flush writes back modified then invalidates; others invalidate; non-coherent miss nothing.
// - Coherent block-flush broadcasts flush unless a modified hit writes back instead; disabled caches stay untouched.
// - Block-allocate acts as block-zero but no-ops wherever that would fault.
// - Block-invalidate checked as store, invalidates any hit, supervisor only.
// - Coherent block-invalidate broadcasts kill; disabled caches stay untouched.
// - Instruction invalidate translated as data, broadcast with its coherency attribute.
// - Instruction invalidate snoops checked when global, own ones whatever the global signal.
// - Instruction invalidate acts even if disabled or locked; L2 untouched.
module ccb_ctrl import ccb_pkg::*; #(
	parameter int AW = 32
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// Operation request from the load/store pipeline
	input wire logic req_valid,
	output logic req_ready,
	input wire ccb_op_t req_op,
	input wire logic [AW-1:0] req_addr,
	input wire logic [ATR_WIDTH-1:0] storage_attribute_bits,
	input wire logic req_ld_fault,
	input wire logic req_st_fault,
	input wire logic req_data_breakpoint_reg_match,
	input wire logic problem_state_bit,
	// Lookup results for the request address
	input wire logic l1_hit,
	input wire ccb_cst_t l1_state,
	input wire logic l2_hit,
	input wire ccb_cst_t l2_state,
	// Cache configuration
	input wire logic dc_enable,
	input wire logic dc_lock,
	input wire logic l2_enable,
	input wire logic bus_alt_mode,
	// Completion and exceptions
	output logic op_done,
	output logic op_busy,
	output logic exc_align,
	output logic exc_dsi,
	output logic exc_priv,
	// Data cache update
	output logic l1_wr_valid,
	output logic [AW-1:0] l1_wr_addr,
	output ccb_cst_t l1_wr_state,
	output logic l1_wr_zero,
	output logic l1_from_l2,
	// System bus
	output logic bus_req,
	output ccb_bcmd_t bus_cmd,
	output logic [AW-1:0] bus_addr,
	output logic bus_global,
	input wire logic bus_ack,
	input wire logic fill_done,
	// Snooped transactions
	input wire logic snp_valid,
	input wire ccb_bcmd_t snp_cmd,
	input wire logic [AW-1:0] snp_addr,
	input wire logic global_attr_signal,
	input wire logic snp_own,
	// Instruction cache invalidate
	output logic ic_inv_valid,
	output logic [AW-1:0] ic_inv_addr,
	// Committed store queue probe
	input wire logic st_valid,
	input wire logic [AW-1:0] st_addr,
	output logic store_stall
);
	typedef struct packed {
		ccb_fsm_t fsm;
		logic upd_pend;
		ccb_cst_t upd_state;
		logic upd_zero;
		logic done;
		logic ex_al;
		logic ex_dsi;
		logic ex_prv;
		logic l1_v;
		logic [AW-1:0] l1_addr;
		ccb_cst_t l1_st;
		logic l1_z;
		logic l2f;
		ccb_bcmd_t cmd;
		logic [AW-1:0] addr;
		logic glob;
		logic ic_v;
		logic [AW-1:0] ic_addr;
	} ccb_state_t;
	ccb_state_t q;
	ccb_state_t d;

	ccb_trk_if #(.AW(AW)) trk ();

	ccb_fill_trk #(.AW(AW)) ccb_fill_trk_i (
		.core_clk(core_clk),
		.srst(srst),
		.trk(trk)
	);

	logic take;
	logic fill_ret;
	logic hit_en;
	logic coh;
	logic zero_bad;
	assign fill_ret = fill_done && trk.busy;
	assign req_ready = (q.fsm == FS_IDLE) && !fill_ret &&
		!(req_op == OP_TST && trk.busy);
	assign take = req_valid && req_ready;
	// Disabled data cache is never touched, so a hit counts only when enabled
	assign hit_en = l1_hit && dc_enable;
	assign coh = storage_attribute_bits[ATR_M];
	assign zero_bad = !dc_enable || dc_lock || storage_attribute_bits[ATR_I] ||
		storage_attribute_bits[ATR_W];

	always_comb begin
		logic go_bus;
		logic fin;
		logic upd;
		ccb_cst_t ust;
		logic uz;
		ccb_bcmd_t cmd;
		go_bus = 1'h0;
		fin = 1'h0;
		upd = 1'h0;
		ust = CS_INV;
		uz = 1'h0;
		cmd = BC_KILL;
		d = q;
		d.done = 1'h0;
		d.ex_al = 1'h0;
		d.ex_dsi = 1'h0;
		d.ex_prv = 1'h0;
		d.l1_v = 1'h0;
		d.l1_z = 1'h0;
		d.l2f = 1'h0;
		// own broadcasts count whatever the global signal
		// no enable, lock or L2 term gates this
		d.ic_v = snp_valid && snp_cmd == BC_ICBI && (global_attr_signal || snp_own);
		d.ic_addr = snp_addr;
		trk.set = 1'h0;
		trk.set_addr = req_addr;
		trk.clr = fill_ret;
		if (fill_ret) begin
			d.l1_v = 1'h1;
			d.l1_addr = trk.addr;
			d.l1_st = CS_EXC;
		end else if (take) begin
			unique case (req_op)
				OP_TST: begin
					if (storage_attribute_bits[ATR_W] || storage_attribute_bits[ATR_I] ||
						req_ld_fault || !dc_enable || dc_lock) begin
						fin = 1'h1;
					end else if (l1_hit) begin
						fin = 1'h1;
					end else if (l2_hit && l2_enable) begin
						fin = 1'h1;
						upd = 1'h1;
						ust = l2_state;
						d.l2f = 1'h1;
					end else begin
						go_bus = 1'h1;
						cmd = bus_alt_mode ? BC_RCLAIM : BC_RWITM;
						// fill kept apart from store merging
						trk.set = 1'h1;
					end
				end
				OP_BZ, OP_BA: begin
					if (zero_bad || req_st_fault || req_data_breakpoint_reg_match) begin
						fin = 1'h1;
						if (req_op == OP_BZ) begin
							d.ex_al = zero_bad;
							d.ex_dsi = !zero_bad;
						end
					end else begin
						upd = 1'h1;
						uz = 1'h1;
						ust = CS_MOD;
						if (!coh || (hit_en && (l1_state == CS_MOD || l1_state == CS_EXC))) begin
							fin = 1'h1;
						end else begin
							go_bus = 1'h1;
							cmd = BC_KILL;
						end
					end
				end
				OP_BST: begin
					if (req_ld_fault) begin
						fin = 1'h1;
						d.ex_dsi = 1'h1;
					end else if (hit_en && l1_state == CS_MOD) begin
						go_bus = 1'h1;
						cmd = BC_WRBACK;
						upd = 1'h1;
						ust = CS_EXC;
					end else if (hit_en || coh) begin
						go_bus = 1'h1;
						cmd = BC_CLEAN;
					end else begin
						fin = 1'h1;
					end
				end
				OP_BF: begin
					if (req_ld_fault) begin
						fin = 1'h1;
						d.ex_dsi = 1'h1;
					end else begin
						upd = hit_en;
						ust = CS_INV;
						if (hit_en && l1_state == CS_MOD) begin
							go_bus = 1'h1;
							cmd = BC_WRBACK;
						end else if (coh) begin
							go_bus = 1'h1;
							cmd = BC_FLUSH;
						end else begin
							fin = 1'h1;
						end
					end
				end
				OP_BI: begin
					if (problem_state_bit) begin
						fin = 1'h1;
						d.ex_prv = 1'h1;
					end else if (req_st_fault) begin
						fin = 1'h1;
						d.ex_dsi = 1'h1;
					end else begin
						upd = hit_en;
						ust = CS_INV;
						if (coh) begin
							go_bus = 1'h1;
							cmd = BC_KILL;
						end else begin
							fin = 1'h1;
						end
					end
				end
				OP_IBI: begin
					if (req_ld_fault) begin
						fin = 1'h1;
						d.ex_dsi = 1'h1;
					end else begin
						go_bus = 1'h1;
						cmd = BC_ICBI;
					end
				end
				default: begin
					fin = 1'h1;
				end
			endcase
			d.addr = req_addr;
			d.glob = coh;
			if (go_bus) begin
				d.fsm = FS_BUS;
				d.cmd = cmd;
				d.upd_pend = upd;
				d.upd_state = ust;
				d.upd_zero = uz;
			end else begin
				d.done = fin;
				d.l1_v = upd;
				d.l1_addr = req_addr;
				d.l1_st = ust;
				d.l1_z = uz;
			end
		end else if (q.fsm == FS_BUS && bus_ack) begin
			d.fsm = FS_IDLE;
			d.done = 1'h1;
			d.l1_v = q.upd_pend;
			d.l1_addr = q.addr;
			d.l1_st = q.upd_state;
			d.l1_z = q.upd_zero;
			d.upd_pend = 1'h0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign trk.st_addr = st_addr;
	assign store_stall = st_valid && trk.hit;
	assign op_busy = q.fsm == FS_BUS;
	assign op_done = q.done;
	assign exc_align = q.ex_al;
	assign exc_dsi = q.ex_dsi;
	assign exc_priv = q.ex_prv;
	assign l1_wr_valid = q.l1_v;
	assign l1_wr_addr = q.l1_addr;
	assign l1_wr_state = q.l1_st;
	assign l1_wr_zero = q.l1_z;
	assign l1_from_l2 = q.l2f;
	assign bus_req = q.fsm == FS_BUS;
	assign bus_cmd = q.cmd;
	assign bus_addr = q.addr;
	assign bus_global = q.glob;
	assign ic_inv_valid = q.ic_v;
	assign ic_inv_addr = q.ic_addr;

	property p_tst_wt;
		@(posedge core_clk) disable iff (srst)
		take && req_op == OP_TST && storage_attribute_bits[ATR_W]
			|=> op_done && !bus_req && !l1_wr_valid;
	endproperty
	a_tst_wt: assert property (p_tst_wt) else $error("touch-store write-through acted");

	property p_tst_hit;
		@(posedge core_clk) disable iff (srst)
		take && req_op == OP_TST && l1_hit && dc_enable && !dc_lock &&
			!storage_attribute_bits[ATR_W] && !storage_attribute_bits[ATR_I] && !req_ld_fault
			|=> op_done && !l1_wr_valid;
	endproperty
	a_tst_hit: assert property (p_tst_hit) else $error("touch-store hit changed state");

	property p_tst_l2;
		@(posedge core_clk) disable iff (srst)
		take && req_op == OP_TST && !l1_hit && l2_hit && l2_enable && dc_enable &&
			!dc_lock && !storage_attribute_bits[ATR_W] && !storage_attribute_bits[ATR_I] &&
			!req_ld_fault
			|=> l1_wr_valid && l1_from_l2 && l1_wr_state == $past(l2_state);
	endproperty
	a_tst_l2: assert property (p_tst_l2) else $error("L2 state not copied");

	sequence s_fill_ret;
		fill_done && trk.busy;
	endsequence
	property p_tst_fill;
		@(posedge core_clk) disable iff (srst)
		s_fill_ret |=> l1_wr_valid && l1_wr_state == CS_EXC && !trk.busy;
	endproperty
	a_tst_fill: assert property (p_tst_fill) else $error("fill not exclusive");

	property p_bz_fast;
		@(posedge core_clk) disable iff (srst)
		take && req_op == OP_BZ && !zero_bad && !req_st_fault && !req_data_breakpoint_reg_match &&
			coh && hit_en && l1_state == CS_MOD
			|=> l1_wr_valid && l1_wr_zero && l1_wr_state == CS_MOD && !bus_req;
	endproperty
	a_bz_fast: assert property (p_bz_fast) else $error("block-zero hit used bus");

	sequence s_kill_start;
		take && req_op == OP_BZ && !zero_bad && !req_st_fault && !req_data_breakpoint_reg_match &&
			coh && !hit_en;
	endsequence
	sequence s_kill_wait;
		bus_req && bus_cmd == BC_KILL && !l1_wr_valid;
	endsequence
	property p_bz_kill;
		@(posedge core_clk) disable iff (srst)
		s_kill_start |=> s_kill_wait;
	endproperty
	a_bz_kill: assert property (p_bz_kill) else $error("block-zero miss skipped kill");

	property p_bz_align;
		@(posedge core_clk) disable iff (srst)
		take && req_op == OP_BZ && zero_bad |=> op_done && exc_align && !exc_dsi;
	endproperty
	a_bz_align: assert property (p_bz_align) else $error("missing alignment fault");

	property p_ba_quiet;
		@(posedge core_clk) disable iff (srst)
		take && req_op == OP_BA |=> !exc_align && !exc_dsi && !exc_priv;
	endproperty
	a_ba_quiet: assert property (p_ba_quiet) else $error("block-allocate faulted");

	property p_bi_priv;
		@(posedge core_clk) disable iff (srst)
		take && req_op == OP_BI && problem_state_bit |=> exc_priv && !l1_wr_valid && !bus_req;
	endproperty
	a_bi_priv: assert property (p_bi_priv) else $error("user block-invalidate ran");

	property p_ic_snoop;
		@(posedge core_clk) disable iff (srst)
		snp_valid && snp_cmd == BC_ICBI && snp_own
			|=> ic_inv_valid && ic_inv_addr == $past(snp_addr);
	endproperty
	a_ic_snoop: assert property (p_ic_snoop) else $error("own invalidate not snooped");

	property p_bus_hold;
		@(posedge core_clk) disable iff (srst)
		bus_req && !bus_ack |=> bus_req && op_busy && !op_done && $stable(bus_cmd);
	endproperty
	a_bus_hold: assert property (p_bus_hold) else $error("op done before bus accept");
endmodule

/* common/ccb_pkg.sv */
// Shared encodings for the cache block control operation logic.
// Assumes one processor clock domain and 32-byte coherency blocks.
package ccb_pkg;
	// Low address bits that select a byte inside a cache block
	localparam int BLK_OFS = 5;
	// Bit positions inside the storage_attribute_bits field (W I M G)
	localparam int ATR_W = 3;
	localparam int ATR_I = 2;
	localparam int ATR_M = 1;
	localparam int ATR_G = 0;
	localparam int ATR_WIDTH = 4;
	typedef enum logic [2:0] {
		OP_TST, OP_BZ, OP_BA, OP_BST, OP_BF, OP_BI, OP_IBI
	} ccb_op_t;
	typedef enum logic [2:0] {
		CS_INV, CS_SHR, CS_EXC, CS_MOD, CS_REC
	} ccb_cst_t;
	typedef enum logic [2:0] {
		BC_RWITM, BC_RCLAIM, BC_KILL, BC_CLEAN, BC_FLUSH, BC_WRBACK, BC_ICBI
	} ccb_bcmd_t;
	typedef enum logic {
		FS_IDLE, FS_BUS
	} ccb_fsm_t;
endpackage

/* common/ccb_trk_if.sv */
// Link between the operation sequencer and the touch-for-store fill tracker.
// Both ends sit on core_clk.
`timescale 1ns/1ns
interface ccb_trk_if #(parameter int AW = 32);
	logic set;
	logic clr;
	logic [AW-1:0] set_addr;
	logic [AW-1:0] st_addr;
	logic busy;
	logic [AW-1:0] addr;
	logic hit;
	modport seq (output set, output clr, output set_addr, output st_addr,
		input busy, input addr, input hit);
	modport trk (input set, input clr, input set_addr, input st_addr,
		output busy, output addr, output hit);
endinterface

/* verilog/ccb_fill_trk.sv */
// Tracker for the one outstanding touch-for-store fill.
// Assumes set and clr come from the sequencer on core_clk.
`timescale 1ns/1ns
module ccb_fill_trk import ccb_pkg::*; #(
	parameter int AW = 32
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// Sequencer link
	ccb_trk_if.trk trk
);
	typedef struct packed {
		logic pend;
		logic [AW-1:0] addr;
	} ccb_trk_state_t;
	ccb_trk_state_t trk_q;
	ccb_trk_state_t trk_d;

	always_comb begin
		trk_d = trk_q;
		if (trk.clr) begin
			trk_d.pend = 1'h0;
		end
		// A new fill wins over the retiring one
		if (trk.set) begin
			trk_d.pend = 1'h1;
			trk_d.addr = trk.set_addr;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			trk_q <= '0;
		end else begin
			trk_q <= trk_d;
		end
	end

	assign trk.busy = trk_q.pend;
	assign trk.addr = trk_q.addr;
	assign trk.hit = trk_q.pend &&
		(trk.st_addr[AW-1:BLK_OFS] == trk_q.addr[AW-1:BLK_OFS]);
endmodule

/* bench/ccb_bus_model.sv */
// Far side of the block: system bus that accepts requests and snoops.
// Assumes the block holds bus_req and its qualifiers until bus_ack.
`timescale 1ns/1ns
module ccb_bus_model import ccb_pkg::*; (
	// Clock, reset and pacing
	input wire logic core_clk,
	input wire logic srst,
	input wire logic [3:0] ack_dly,
	// Requests from the block
	input wire logic bus_req,
	input wire ccb_bcmd_t bus_cmd,
	input wire logic [31:0] bus_addr,
	input wire logic bus_global,
	output logic bus_ack,
	output logic fill_done,
	// Snooped traffic
	output logic snp_valid,
	output ccb_bcmd_t snp_cmd,
	output logic [31:0] snp_addr,
	output logic global_attr_signal,
	output logic snp_own
);
	logic [3:0] cnt;
	logic [3:0] fcnt;
	always_ff @(posedge core_clk) begin
		bus_ack <= 1'b0;
		fill_done <= 1'b0;
		snp_valid <= 1'b0;
		snp_addr <= ~snp_addr;
		if (srst) begin
			cnt <= 4'h0;
			fcnt <= 4'h0;
			snp_addr <= 32'h0;
			snp_cmd <= BC_RWITM;
			snp_own <= 1'b0;
			global_attr_signal <= 1'b0;
		end else begin
			// Acceptance after a chosen wait
			if (bus_req && !bus_ack) begin
				cnt <= (cnt == ack_dly) ? 4'h0 : cnt + 4'h1;
				bus_ack <= (cnt == ack_dly);
			end
			if (bus_req && bus_ack) begin
				if (bus_cmd == BC_RWITM || bus_cmd == BC_RCLAIM)
					fcnt <= 4'h8;
				// Own instruction invalidates come back as snoops
				if (bus_cmd == BC_ICBI) begin
					snp_valid <= 1'b1;
					snp_cmd <= BC_ICBI;
					snp_addr <= bus_addr;
					global_attr_signal <= bus_global;
					snp_own <= 1'b1;
				end
			end
			if (fcnt != 4'h0) begin
				fcnt <= fcnt - 4'h1;
				fill_done <= (fcnt == 4'h1);
			end
		end
	end
endmodule

/* bench/cache_block_control_ops_tb.sv */
// Self-checking bench for the cache block control sequencer.
// Assumes the bus model answers every request and returns touch fills.
`timescale 1ns/1ns
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin err_count++; \
	$display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module cache_block_control_ops_tb import ccb_pkg::*;;
	logic core_clk = 0, srst = 1, req_valid = 0, ld_f = 0, st_f = 0, data_breakpoint_reg = 0, pr = 0;
	logic l1_hit = 0, l2_hit = 0, dc_enable = 1, dc_lock = 0, l2_enable = 1, alt = 0;
	logic st_valid = 0;
	logic [31:0] addr = 32'h0, st_addr = 32'h0;
	logic [3:0] attr = 4'h0, ack_dly = 4'h0;
	ccb_op_t op = OP_TST;
	ccb_cst_t l1_state = CS_INV, l2_state = CS_INV, l1_wr_state, g_t;
	ccb_bcmd_t bus_cmd, snp_cmd, g_c;
	logic req_ready, op_done, op_busy, exc_align, exc_dsi, exc_priv, l1_wr_valid, bus_req;
	logic bus_global, bus_ack, fill_done, snp_valid, global_attr_signal, snp_own;
	logic ic_inv_valid, store_stall, g_b, g_w, g_ea, g_ed, g_ep, g_ic;
	logic l1_wr_zero, l1_from_l2, g_z, g_l2, g_g, g_ob;
	logic [31:0] l1_wr_addr, ic_inv_addr, g_a, g_wa, g_ia;
	logic [31:0] bus_addr, snp_addr;
	int err_count = 0, total_checks = 0;
	always #2 core_clk = ~core_clk;
	ccb_ctrl #(.AW(32)) ccb_ctrl_i (.core_clk, .srst, .req_valid, .req_ready, .req_op(op),
		.req_addr(addr), .storage_attribute_bits(attr), .req_ld_fault(ld_f),
		.req_st_fault(st_f), .req_data_breakpoint_reg_match(data_breakpoint_reg), .problem_state_bit(pr), .l1_hit,
		.l1_state, .l2_hit, .l2_state, .dc_enable, .dc_lock, .l2_enable, .bus_alt_mode(alt),
		.op_done, .op_busy, .exc_align, .exc_dsi, .exc_priv, .l1_wr_valid, .l1_wr_addr,
		.l1_wr_state, .l1_wr_zero, .l1_from_l2, .bus_req, .bus_cmd, .bus_addr,
		.bus_global, .bus_ack, .fill_done, .snp_valid, .snp_cmd, .snp_addr,
		.global_attr_signal, .snp_own, .ic_inv_valid, .ic_inv_addr, .st_valid, .st_addr,
		.store_stall);
	ccb_bus_model ccb_bus_model_i (.core_clk, .srst, .ack_dly, .bus_req, .bus_cmd,
		.bus_addr, .bus_global, .bus_ack, .fill_done, .snp_valid, .snp_cmd, .snp_addr,
		.global_attr_signal, .snp_own);
	always @(negedge core_clk) begin
		if (bus_req && bus_ack) begin
			g_b = 1;
			g_c = bus_cmd;
			g_a = bus_addr;
			g_g = bus_global;
		end
		if (op_busy)
			g_ob = 1;
		if (l1_wr_valid) begin
			g_w = 1;
			g_t = l1_wr_state;
			g_wa = l1_wr_addr;
			g_z = l1_wr_zero;
			g_l2 = l1_from_l2;
		end
		if (ic_inv_valid) begin
			g_ic = 1;
			g_ia = ic_inv_addr;
		end
		if (op_done)
			{g_ea, g_ed, g_ep} = {exc_align, exc_dsi, exc_priv};
	end
	// Bus use, cache write and exceptions the operation should produce
	function automatic logic [10:0] exp_f();
		logic b, w, ea, ed, ep, hit, m;
		ccb_bcmd_t c;
		ccb_cst_t t;
		{b, w, ea, ed, ep} = 5'h0;
		c = BC_KILL;
		t = CS_INV;
		m = attr[ATR_M];
		hit = l1_hit && dc_enable;
		case (op)
			OP_TST: if (!(attr[ATR_W] | attr[ATR_I] | ld_f | !dc_enable | dc_lock | l1_hit)) begin
				if (l2_hit && l2_enable) begin
					w = 1;
					t = l2_state;
				end else begin
					b = 1;
					c = alt ? BC_RCLAIM : BC_RWITM;
				end
			end
			OP_BZ, OP_BA: if (!dc_enable | dc_lock | attr[ATR_I] | attr[ATR_W]) ea = (op == OP_BZ);
				else if (st_f | data_breakpoint_reg) ed = (op == OP_BZ);
				else begin
					w = 1;
					t = CS_MOD;
					b = m && !(hit && (l1_state == CS_MOD || l1_state == CS_EXC));
				end
			OP_BST: if (ld_f) ed = 1;
				else if (hit && l1_state == CS_MOD) begin
					{b, w} = 2'h3;
					c = BC_WRBACK;
					t = CS_EXC;
				end else begin
					b = hit | m;
					c = BC_CLEAN;
				end
			OP_BF: if (ld_f) ed = 1;
				else if (hit && l1_state == CS_MOD) begin
					{b, w} = 2'h3;
					c = BC_WRBACK;
				end else begin
					{b, w} = {m, hit};
					c = BC_FLUSH;
				end
			OP_BI: if (pr) ep = 1;
				else if (st_f) ed = 1;
				else {b, w} = {m, hit};
			default: if (ld_f) ed = 1;
				else begin
					b = 1;
					c = BC_ICBI;
				end
		endcase
		if (!b)
			c = BC_RWITM;
		return {b, c, w, t, ea, ed, ep};
	endfunction
	task go;
		int n;
		logic [10:0] e;
		begin
			{g_b, g_w, g_ea, g_ed, g_ep, g_ic} = 6'h0;
			{g_z, g_l2, g_g, g_ob} = 4'h0;
			{g_a, g_wa, g_ia} = 96'h0;
			g_c = BC_RWITM;
			g_t = CS_INV;
			n = 0;
			req_valid = 1;
			#1;
			while (!req_ready && n < 100) begin
				@(negedge core_clk);
				#1;
				n++;
			end
			@(negedge core_clk);
			req_valid = 0;
			while (!op_done && n < 300) begin
				@(negedge core_clk);
				n++;
			end
			#1;
			e = exp_f();
			`CHK("done", 1'b1, op_done)
			`CHK("bus", e[10:7], {g_b, g_c})
			`CHK("l1wr", e[6:3], {g_w, g_t})
			`CHK("exc", e[2:0], {g_ea, g_ed, g_ep})
			`CHK("busside", e[10] ? {addr, attr[ATR_M]} : 33'h0, {g_a, g_g})
			`CHK("busy", e[10], g_ob)
			`CHK("l1side", e[6] ? {addr, op == OP_BZ || op == OP_BA, op == OP_TST} : 34'h0, {g_wa, g_z, g_l2})
			if (op == OP_TST && e[10]) begin
				@(negedge core_clk);
				st_valid = 1;
				st_addr = addr;
				#1;
				`CHK("stall", 1'b1, store_stall)
				while (!l1_wr_valid && n < 400) begin
					@(negedge core_clk);
					n++;
				end
				`CHK("fill", CS_EXC, l1_wr_state)
				`CHK("filladdr", addr, l1_wr_addr)
				`CHK("unstall", 1'b0, store_stall)
				st_valid = 0;
			end
			repeat (3) @(negedge core_clk);
			`CHK("icinv", op == OP_IBI && !ld_f, g_ic)
			`CHK("icaddr", (op == OP_IBI && !ld_f) ? addr : 32'h0, g_ia)
		end
	endtask
	task rnd;
		begin
			op = ccb_op_t'($urandom % 7);
			attr = 4'($urandom);
			addr = $urandom;
			l1_hit = 1'($urandom);
			l1_state = l1_hit ? ccb_cst_t'(1 + $urandom % 4) : CS_INV;
			l2_hit = 1'($urandom);
			l2_state = l2_hit ? ccb_cst_t'(1 + $urandom % 4) : CS_INV;
			{ld_f, st_f, data_breakpoint_reg} = {$urandom % 6 == 0, $urandom % 6 == 0, $urandom % 6 == 0};
			{pr, dc_enable, dc_lock} = {$urandom % 3 == 0, $urandom % 5 != 0, $urandom % 6 == 0};
			{l2_enable, alt} = 2'($urandom);
			ack_dly = 4'($urandom % 6);
		end
	endtask
	task results;
		begin
			$display("checks %0d errors %0d", total_checks, err_count);
			if (err_count == 0 && total_checks > 0)
				$display("STATUS OK");
			else
				$display("STATUS NOT OK");
			$finish;
		end
	endtask
	initial begin
		#200000;
		err_count++;
		results();
	end
	initial begin
		void'($urandom(32'hD4DE));
		repeat (12) @(negedge core_clk);
		srst = 0;
		`CHK("ready", 1'b1, req_ready)
		// Coherent misses of every operation code
		for (int i = 0; i < 7; i++) begin
			op = ccb_op_t'(i);
			attr = 4'h2;
			go();
		end
		alt = 1;
		op = OP_TST;
		go();
		op = OP_IBI;
		attr = 4'h0;
		go();
		// Coherent hits of every operation code, modified and shared in turn
		attr = 4'h2;
		l1_hit = 1;
		for (int i = 0; i < 7; i++) begin
			op = ccb_op_t'(i);
			l1_state = (i % 2) ? CS_MOD : CS_SHR;
			go();
		end
		// Touch copy from L2, breakpoint and privilege corners
		l1_hit = 0;
		l2_hit = 1;
		l2_state = CS_REC;
		op = OP_TST;
		go();
		l2_hit = 0;
		data_breakpoint_reg = 1;
		op = OP_BZ;
		go();
		op = OP_BA;
		go();
		data_breakpoint_reg = 0;
		pr = 1;
		op = OP_BI;
		go();
		pr = 0;
		repeat (400) begin
			rnd();
			go();
		end
		results();
	end
endmodule
